// file: pkg/psc_defs.svh
// Constants for the pipeline stall control block
`ifndef PSC_DEFS_SVH
`define PSC_DEFS_SVH
`define PSC_TAG_W        8
`define PSC_WR_CYCLES    2
`define PSC_MAX_DATA_ACC 3'h2
`define PSC_CNT_W        4
`endif

// file: pkg/psc_pkg.sv
// Types shared by the pipeline stall control block
`include "psc_defs.svh"
package psc_pkg;
  typedef struct packed {
    logic [1:0] rd_cnt;
    logic [1:0] st_cnt;
    logic       ext_rd;
    logic       ext_wr;
    logic       ilock;
    logic       ccall;
    logic       areg_wr;
    logic       areg_use;
  } psc_attr_type;

  typedef struct packed {
    logic                  valid;
    logic [`PSC_TAG_W-1:0] tag;
    psc_attr_type          attr;
  } psc_stage_type;
endpackage

// file: rtl/psc_pipeline_stall_control.sv
// Stall and interlock control for a four-stage processor pipeline
// Summary of operation
// RQ1: Fetch, decode, read, execute advance one per cycle
// RQ2: Busy port, long load, conditional call freeze stages
// RQ3: Port busy until started access completes
// RQ4: External data write keeps port two cycles
// RQ5: Load to busy port retried, execute bubbles
// RQ6: Started external read runs to completion
// RQ7: Interlocked load waits for flag acknowledge
// RQ8: Held fetch word refetched, duplicate discarded
// RQ9: Conditional call takes one extra cycle
// RQ10: Return address pushed after condition evaluated
// RQ11: Address register write stalls dependent access
// RQ12: Two stores then read delays read one cycle
// RQ13: Three data accesses advance execute only
// RQ14: Held stage injects bubble downstream each cycle
`timescale 1ns/100ps
`include "psc_defs.svh"
module psc_pipeline_stall_control
  import psc_pkg::*;
#(
  parameter int WR_CYCLES = `PSC_WR_CYCLES
) (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  srst,
  // Fetch stage input
  input  wire logic                  fetch_valid,
  input  wire logic [`PSC_TAG_W-1:0] fetch_tag,
  input  wire logic [1:0]            fetch_rd_cnt,
  input  wire logic [1:0]            fetch_st_cnt,
  input  wire logic                  fetch_ext_rd,
  input  wire logic                  fetch_ext_wr,
  input  wire logic                  fetch_ilock,
  input  wire logic                  fetch_ccall,
  input  wire logic                  fetch_areg_wr,
  input  wire logic                  fetch_areg_use,
  output logic                       fetch_take,
  output logic                       fetch_refetch,
  // External port
  input  wire logic                  ext_rd_ready,
  input  wire logic                  interlock_ack_flag_pin,
  output logic                       ext_rd_start,
  output logic                       ext_wr_start,
  output logic                       port_busy,
  // Conditional call
  input  wire logic                  ex_cond_true,
  output logic                       push_ret,
  // Stage contents
  output logic                       dec_valid,
  output logic [`PSC_TAG_W-1:0]      dec_tag,
  output logic                       rd_valid,
  output logic [`PSC_TAG_W-1:0]      rd_tag,
  output logic                       ex_valid,
  output logic [`PSC_TAG_W-1:0]      ex_tag,
  // Conflict status
  output logic                       hold_all,
  output logic                       exec_only,
  output logic                       areg_conflict
);

  if (WR_CYCLES < 1 || WR_CYCLES > 15) begin : g_wr_range
    $error("WR_CYCLES out of range");
  end

  localparam logic [`PSC_CNT_W-1:0] WR_LOAD = `PSC_CNT_W'(WR_CYCLES - 1);

  psc_stage_type          d_r;
  psc_stage_type          r_r;
  psc_stage_type          e_r;
  psc_stage_type          f_in;
  logic [`PSC_CNT_W-1:0]  wr_cnt_r;
  logic                   rd_active_r;
  logic                   rd_got_r;
  logic                   ccall_x_r;
  logic                   cond_r;
  logic                   rdy_meta_r;
  logic                   rdy_s_r;
  logic                   flag_meta_r;
  logic                   flag_s_r;
  logic                   port_conflict;
  logic                   rd_wait;
  logic                   rd_done;
  logic                   ilock_wait;
  logic                   ccall_hold;
  logic                   e_hold;
  logic                   r_hold;
  logic                   d_hold;

  function automatic logic [2:0] acc_sum(input logic [1:0] a, input logic [1:0] b);
    acc_sum = {1'b0, a} + {1'b0, b};
  endfunction

  function automatic logic writes_areg(input psc_stage_type s);
    writes_areg = s.valid && s.attr.areg_wr;
  endfunction

  // Pin synchronisers
  always_ff @(posedge mclk) begin
    if (srst) begin
      rdy_meta_r  <= 1'b0;
      rdy_s_r     <= 1'b0;
      flag_meta_r <= 1'b0;
      flag_s_r    <= 1'b0;
    end else begin
      rdy_meta_r  <= ext_rd_ready;
      rdy_s_r     <= rdy_meta_r;
      flag_meta_r <= interlock_ack_flag_pin;
      flag_s_r    <= flag_meta_r;
    end
  end

  // Conflict detection
  always_comb begin
    f_in.valid         = fetch_valid;
    f_in.tag           = fetch_tag;
    f_in.attr.rd_cnt   = fetch_rd_cnt;
    f_in.attr.st_cnt   = fetch_st_cnt;
    f_in.attr.ext_rd   = fetch_ext_rd;
    f_in.attr.ext_wr   = fetch_ext_wr;
    f_in.attr.ilock    = fetch_ilock;
    f_in.attr.ccall    = fetch_ccall;
    f_in.attr.areg_wr  = fetch_areg_wr;
    f_in.attr.areg_use = fetch_areg_use;
    ccall_hold    = e_r.valid && e_r.attr.ccall && !ccall_x_r; // [RQ9]
    e_hold        = ccall_hold;
    ext_wr_start  = e_r.valid && e_r.attr.ext_wr && !e_hold;
    port_busy     = ext_wr_start || (wr_cnt_r != '0) || rd_active_r; // [RQ3]
    port_conflict = r_r.valid && (r_r.attr.ext_rd || r_r.attr.ext_wr) &&
                    (ext_wr_start || (wr_cnt_r != '0)); // [RQ5]
    ilock_wait    = r_r.valid && r_r.attr.ilock && flag_s_r; // [RQ7]
    rd_done       = r_r.valid && r_r.attr.ext_rd && !port_conflict &&
                    (rdy_s_r || rd_got_r) && !ilock_wait; // [RQ7]
    rd_wait       = r_r.valid && r_r.attr.ext_rd && !port_conflict &&
                    !rdy_s_r && !rd_got_r; // [RQ6]
    ext_rd_start  = rd_wait && !rd_active_r;
    exec_only     = r_r.valid && e_r.valid && !e_hold &&
                    (acc_sum(r_r.attr.rd_cnt, e_r.attr.st_cnt) > `PSC_MAX_DATA_ACC) ||
                    ilock_wait; // [RQ12] [RQ13]
    hold_all      = ccall_hold || port_conflict || rd_wait; // [RQ2]
    r_hold        = hold_all || exec_only;
    areg_conflict = d_r.valid && d_r.attr.areg_use &&
                    (writes_areg(r_r) || writes_areg(e_r)); // [RQ11]
    d_hold        = r_hold || areg_conflict;
    fetch_take    = !d_hold;
    fetch_refetch = d_hold && fetch_valid; // [RQ8]
    push_ret      = e_r.valid && e_r.attr.ccall && ccall_x_r && cond_r; // [RQ10]
  end

  // Pipeline stage registers
  always_ff @(posedge mclk) begin
    if (srst) begin
      d_r <= '0;
      r_r <= '0;
      e_r <= '0;
    end else begin
      if (!e_hold) begin
        e_r <= r_hold ? psc_stage_type'('0) : r_r; // [RQ1] [RQ14]
      end
      if (!r_hold) begin
        r_r <= d_hold ? psc_stage_type'('0) : d_r; // [RQ14]
      end
      if (!d_hold) begin
        d_r <= fetch_valid ? f_in : psc_stage_type'('0); // [RQ1] [RQ8]
      end
    end
  end

  // External port occupancy
  always_ff @(posedge mclk) begin
    if (srst) begin
      wr_cnt_r    <= '0;
      rd_active_r <= 1'b0;
      rd_got_r    <= 1'b0;
    end else begin
      if (rd_done) begin
        rd_got_r <= 1'b0;
      end else if (rd_active_r && rdy_s_r) begin
        rd_got_r <= 1'b1; // [RQ7]
      end
      if (ext_wr_start) begin
        wr_cnt_r <= WR_LOAD; // [RQ4]
      end else if (wr_cnt_r != '0) begin
        wr_cnt_r <= wr_cnt_r - `PSC_CNT_W'(1);
      end
      if (rd_done) begin
        rd_active_r <= 1'b0;
      end else if (rd_wait) begin
        rd_active_r <= 1'b1; // [RQ6]
      end
    end
  end

  // Conditional call extra cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      ccall_x_r <= 1'b0;
      cond_r    <= 1'b0;
    end else if (ccall_hold) begin
      ccall_x_r <= 1'b1; // [RQ9]
      cond_r    <= ex_cond_true; // [RQ10]
    end else begin
      ccall_x_r <= 1'b0;
      cond_r    <= 1'b0;
    end
  end

  assign dec_valid = d_r.valid;
  assign dec_tag   = d_r.tag;
  assign rd_valid  = r_r.valid;
  assign rd_tag    = r_r.tag;
  assign ex_valid  = e_r.valid;
  assign ex_tag    = e_r.tag;

  // Checks
  property p_advance;
    @(posedge mclk) disable iff (srst)
    (!d_hold && fetch_valid) |=> (d_r.valid && d_r.tag == $past(fetch_tag));
  endproperty
  a_advance: assert property (p_advance) else $error("fetch not advanced"); // [RQ1]

  property p_hold_all;
    @(posedge mclk) disable iff (srst)
    (port_conflict || rd_wait) |=> ($stable(r_r) && !e_r.valid);
  endproperty
  a_hold_all: assert property (p_hold_all) else $error("hold not applied"); // [RQ2]

  property p_no_rd_busy;
    @(posedge mclk) disable iff (srst)
    (wr_cnt_r != '0) |-> !ext_rd_start;
  endproperty
  a_no_rd_busy: assert property (p_no_rd_busy) else $error("read on busy port"); // [RQ3]

  property p_wr_two;
    @(posedge mclk) disable iff (srst)
    ext_wr_start |=> port_busy ##1 (wr_cnt_r == '0);
  endproperty
  a_wr_two: assert property (p_wr_two) else $error("write busy length wrong"); // [RQ4]

  property p_retry;
    @(posedge mclk) disable iff (srst)
    (r_r.valid && r_r.attr.ext_rd && port_conflict) |=> $stable(r_r);
  endproperty
  a_retry: assert property (p_retry) else $error("load not retried"); // [RQ5]

  property p_rd_cont;
    @(posedge mclk) disable iff (srst)
    (rd_active_r && !rd_done) |=> (rd_active_r || rd_done || !r_r.attr.ext_rd) && !ext_rd_start;
  endproperty
  a_rd_cont: assert property (p_rd_cont) else $error("read restarted"); // [RQ6]

  property p_ilock;
    @(posedge mclk) disable iff (srst)
    ilock_wait |=> ($stable(r_r) && !e_r.valid);
  endproperty
  a_ilock: assert property (p_ilock) else $error("interlocked load not held"); // [RQ7]

  property p_refetch;
    @(posedge mclk) disable iff (srst)
    d_hold |-> (!fetch_take ##1 $stable(d_r));
  endproperty
  a_refetch: assert property (p_refetch) else $error("held fetch word lost"); // [RQ8]

  property p_ccall;
    @(posedge mclk) disable iff (srst)
    ccall_hold |=> (ccall_x_r && $stable(e_r)) ##1 !ccall_x_r;
  endproperty
  a_ccall: assert property (p_ccall) else $error("call extra cycle wrong"); // [RQ9]

  property p_push;
    @(posedge mclk) disable iff (srst)
    push_ret |-> $past(ccall_hold) && $past(ex_cond_true);
  endproperty
  a_push: assert property (p_push) else $error("push before evaluation"); // [RQ10]

  property p_areg;
    @(posedge mclk) disable iff (srst)
    (areg_conflict && !r_hold) |=> !r_r.valid;
  endproperty
  a_areg: assert property (p_areg) else $error("address conflict not stalled"); // [RQ11]

  property p_exec_only;
    @(posedge mclk) disable iff (srst)
    (exec_only && !ilock_wait) |=> (!e_r.valid && $stable(r_r)) ##1 !exec_only;
  endproperty
  a_exec_only: assert property (p_exec_only) else $error("exec only wrong"); // [RQ12] [RQ13]

  property p_bubble;
    @(posedge mclk) disable iff (srst)
    (d_hold && !r_hold) |=> !r_r.valid;
  endproperty
  a_bubble: assert property (p_bubble) else $error("no bubble injected"); // [RQ14]

  c_wr_then_rd: cover property (@(posedge mclk) disable iff (srst) ext_wr_start && port_conflict);
  c_long_rd: cover property (@(posedge mclk) disable iff (srst) rd_active_r [*3] ##1 rd_done);
  c_push: cover property (@(posedge mclk) disable iff (srst) push_ret);
  c_ilock: cover property (@(posedge mclk) disable iff (srst) ilock_wait ##1 !ilock_wait);

endmodule

// file: dv/psc_ext_mem_model.sv
// Model of external memory and the acknowledge flag pin
`timescale 1ns/100ps
module psc_ext_mem_model (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       srst,
  // Read request and latency
  input  wire logic       ext_rd_start,
  input  wire logic [3:0] lat,
  // Pin answers
  output logic            ext_rd_ready,
  output logic            interlock_ack_flag_pin
);
  logic [3:0] cnt_r;

  // Read stays busy for lat cycles after it starts
  always_ff @(posedge mclk) begin
    if (srst) begin
      cnt_r <= 4'h0;
    end else if (ext_rd_start) begin
      cnt_r <= lat;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end

  // Slow memory pulses ready once, lat cycles after the start; flag drops a cycle later
  assign ext_rd_ready           = (lat == 4'h0) || (cnt_r == 4'h1);
  assign interlock_ack_flag_pin = (cnt_r != 4'h0) || ext_rd_start;
endmodule

// file: dv/testbench.sv
// Self-checking bench for the pipeline stall control block
`timescale 1ns/100ps
module testbench;
  import psc_pkg::*;
  logic         mclk, srst, fv, cond, take, refetch, rdy, flag;
  logic         rds, wrs, busy, push, dv, rv, xv, hold, eo, arc, lv;
  logic [7:0]   ftag, dt, rt, xt, lt;
  logic [3:0]   lat;
  psc_attr_type fa;
  int           mismatches, cmp_count, cyc, n_push, n_busy, n_eo, n_ar, n_ref;
  int           wr_cyc, rd_cyc, n_hold;
  int           fx [256];
  bit           seen [256];

  psc_pipeline_stall_control u_dut (
    .mclk(mclk), .srst(srst), .fetch_valid(fv), .fetch_tag(ftag),
    .fetch_rd_cnt(fa.rd_cnt), .fetch_st_cnt(fa.st_cnt), .fetch_ext_rd(fa.ext_rd),
    .fetch_ext_wr(fa.ext_wr), .fetch_ilock(fa.ilock), .fetch_ccall(fa.ccall),
    .fetch_areg_wr(fa.areg_wr), .fetch_areg_use(fa.areg_use),
    .fetch_take(take), .fetch_refetch(refetch), .ext_rd_ready(rdy),
    .interlock_ack_flag_pin(flag), .ext_rd_start(rds), .ext_wr_start(wrs),
    .port_busy(busy), .ex_cond_true(cond), .push_ret(push),
    .dec_valid(dv), .dec_tag(dt), .rd_valid(rv), .rd_tag(rt),
    .ex_valid(xv), .ex_tag(xt), .hold_all(hold), .exec_only(eo),
    .areg_conflict(arc));

  psc_ext_mem_model u_mem (
    .mclk(mclk), .srst(srst), .ext_rd_start(rds), .lat(lat),
    .ext_rd_ready(rdy), .interlock_ack_flag_pin(flag));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %0d exp %0d", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    $display("Compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Monitor: stamp the cycle each word first enters execute
  always @(posedge mclk) begin
    cyc++;
    if (!srst) begin
      n_push += push; n_busy += busy; n_eo += eo; n_ar += arc; n_ref += refetch;
      n_hold += hold;
      if (wrs) wr_cyc = cyc;
      if (rds) rd_cyc = cyc;
      if (xv && !(lv && lt === xt)) begin
        chk(seen[xt], 1'b0);
        seen[xt] = 1'b1;
        fx[xt] = cyc;
      end
      lv = xv;
      lt = xt;
    end
  end

  task automatic clr;
    n_push = 0; n_busy = 0; n_eo = 0; n_ar = 0; n_ref = 0; n_hold = 0;
  endtask

  // Offer a word at a falling edge until it is taken
  task automatic issue(input logic [7:0] t, input logic [9:0] a);
    int k;
    fv = 1'b1; ftag = t; fa = a;
    for (k = 0; k < 40; k++) begin
      #1;
      if (take === 1'b1) break;
      @(negedge mclk);
    end
    if (k == 40) begin
      mismatches++;
      finish_test();
    end
    @(negedge mclk);
  endtask

  task automatic drain(input logic [7:0] t);
    int k;
    fv = 1'b0;
    for (k = 0; k < 60 && !seen[t]; k++) @(negedge mclk);
    if (!seen[t]) begin
      mismatches++;
      finish_test();
    end
    repeat (4) @(negedge mclk);
  endtask

  task automatic t_flow;
    issue(8'h01, 10'h000); issue(8'h02, 10'h000);
    chk(16'({dv, dt}), 16'h0102);
    chk(16'({rv, rt}), 16'h0101);
    issue(8'h03, 10'h000); drain(8'h03);
    chk(16'(fx[2] - fx[1]), 16'h0001);
    chk(16'(fx[3] - fx[2]), 16'h0001);
  endtask

  task automatic t_port;
    clr(); lat = 4'h1; issue(8'h10, 10'h050); drain(8'h10);
    chk(16'(n_busy), 16'h0002);
    issue(8'h11, 10'h050); issue(8'h12, 10'h120); drain(8'h12);
    chk(16'(rd_cyc - wr_cyc), 16'h0002);
    chk(16'(fx[8'h12] - fx[8'h11] > 2), 16'h0001);
  endtask

  task automatic t_long;
    clr(); lat = 4'h5; issue(8'h13, 10'h120); issue(8'h14, 10'h000); drain(8'h14);
    chk(16'(fx[8'h13] - rd_cyc > 5), 16'h0001);
    chk(16'(n_busy >= 5), 16'h0001);
  endtask

  task automatic t_ilock;
    clr(); lat = 4'h4; issue(8'h15, 10'h128); issue(8'h16, 10'h000);
    issue(8'h17, 10'h000); drain(8'h17);
    chk(16'(fx[8'h15] - rd_cyc > 7), 16'h0001);
    chk(16'(n_ref > 0), 16'h0001);
  endtask

  task automatic t_call(input logic c, input logic [7:0] b);
    clr(); cond = c; issue(b, 10'h004); issue(b + 8'h01, 10'h000); drain(b + 8'h01);
    chk(16'(fx[b + 8'h01] - fx[b]), 16'h0002);
    chk(16'(n_push), {15'h0000, c});
    chk(16'(n_hold), 16'h0001);
  endtask

  task automatic t_access;
    clr(); issue(8'h20, 10'h080); issue(8'h21, 10'h100); issue(8'h22, 10'h000); drain(8'h22);
    chk(16'(fx[8'h21] - fx[8'h20]), 16'h0002);
    chk(16'(fx[8'h22] - fx[8'h21]), 16'h0001);
    issue(8'h23, 10'h040); issue(8'h24, 10'h200); drain(8'h24);
    chk(16'(fx[8'h24] - fx[8'h23]), 16'h0002);
    chk(16'(n_eo > 0), 16'h0001);
    issue(8'h25, 10'h040); issue(8'h26, 10'h100); drain(8'h26);
    chk(16'(fx[8'h26] - fx[8'h25]), 16'h0001);
  endtask

  task automatic t_areg;
    clr(); issue(8'h27, 10'h002); issue(8'h28, 10'h001); drain(8'h28);
    chk(16'(n_ar > 0), 16'h0001);
    chk(16'(fx[8'h28] - fx[8'h27] > 1), 16'h0001);
  endtask

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  initial begin
    srst = 1'b1; fv = 1'b0; ftag = 8'h00; fa = '0; cond = 1'b0; lat = 4'h0;
    lv = 1'b0; lt = 8'h00;
    repeat (6) @(negedge mclk);
    srst = 1'b0;
    @(negedge mclk);
    t_flow();
    t_port();
    t_long();
    t_ilock();
    t_call(1'b1, 8'h30);
    t_call(1'b0, 8'h40);
    t_access();
    t_areg();
    finish_test();
  end
endmodule
